// ---- core/serint_regs.svh ----
// register map and field constants of the serial interrupt router
`ifndef SERINT_REGS_SVH
`define SERINT_REGS_SVH

// ---------------------------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------------------------
`define OFS_CTRL0 4'h0
`define OFS_CTRL1 4'h4
`define OFS_STAT0 4'h8
`define OFS_STAT1 4'hC

// ---------------------------------------------------------------
// control register fields
// ---------------------------------------------------------------
`define CTRL_ENA_LSB 0
`define CTRL_ENA_W 4
`define CTRL_GATE_BIT 4
`define CTRL_DESIG_LSB 5
`define CTRL_DESIG_W 2

// ---------------------------------------------------------------
// status register fields
// ---------------------------------------------------------------
`define STAT_COND_LSB 0
`define STAT_LINE_BIT 4
`define STAT_OE_BIT 5

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define CTRL0_RST 7'h00
`define CTRL1_RST 7'h20

`endif

// ---- core/serint_pkg.sv ----
// types shared by the serial interrupt router
package serint_pkg;
  // source enable bits, one per qualifying condition
  typedef logic [3:0] cond_t;
  typedef enum logic [1:0] {
    DESIG_FIRST,
    DESIG_SECOND,
    DESIG_THIRD,
    DESIG_FOURTH
  } desig_e;
  typedef enum {
    BUS_IDLE,
    BUS_ANSWER
  } bus_state_e;
endpackage

// ---- core/serint_port.sv ----
// interrupt qualification for one serial port
`timescale 1ns/1ps
`default_nettype none
module serint_port
  import serint_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_mreset,
  // configuration
  input wire logic [3:0] i_enable,
  input wire logic i_gate,
  // condition levels
  input wire logic [3:0] i_cond,
  // result
  output logic o_req
);
  typedef struct packed {
    logic req;
  } port_s;
  port_s q_r, q_nxt;

  always_comb begin
    q_nxt = q_r;
    // R03 enable and gate
    // R04 any enabled condition
    q_nxt.req = i_gate && |(i_enable & i_cond);
    // R05 reset drops request
    if (i_mreset) begin
      q_nxt.req = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign o_req = q_r.req;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_req_follows: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    ##1 o_req == $past(i_gate && |(i_enable & i_cond) && !i_mreset)) // R04
    else $error("port request does not follow enabled conditions");
  a_gate_blocks: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !i_gate |=> !o_req) // R03
    else $error("request raised with gate clear");
endmodule
`default_nettype wire

// ---- core/serint_router.sv ----
// interrupt router for two serial ports with Avalon-MM registers
// ---------------------------------------------------------------
// What this block does
// R01: second or fourth designation drives the even-designation line.
// R02: first or third designation drives the odd-designation line.
// R03: line high only when source enabled, gate bit set, condition active.
// R04: four conditions: rx error, rx data, tx empty, modem status.
// R05: line low after service, on disable, or on master reset.
// R06: gate bit clear on every port designated to a line releases that line to high impedance.
// R07: master reset active high, restores idle state and defaults.
// R08: host service clears pending conditions so the line can fall.
// ---------------------------------------------------------------
`include "serint_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module serint_router
  import serint_pkg::*;
(
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_ARST_N,
  input wire logic I_MASTER_RESET_IN,
  // condition levels, per port: {modem, thre, rxdata, rxerr}
  input wire logic [3:0] I_COND0,
  input wire logic [3:0] I_COND1,
  // avalon-mm slave
  input wire logic [3:0] I_ADDRESS,
  input wire logic I_READ,
  input wire logic I_WRITE,
  input wire logic [31:0] I_WRITEDATA,
  output logic [31:0] O_READDATA,
  output logic O_WAITREQUEST,
  // interrupt lines, value and output enable
  output logic O_SERIAL_INT_OUT_EVEN_PORT,
  output logic O_SERIAL_INT_OUT_EVEN_PORT_OE,
  output logic O_SERIAL_INT_OUT_ODD_PORT,
  output logic O_SERIAL_INT_OUT_ODD_PORT_OE
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [6:0] ctrl0;
    logic [6:0] ctrl1;
    bus_state_e bus;
    logic [31:0] rdata;
    logic wait_n;
    logic even;
    logic even_oe;
    logic odd;
    logic odd_oe;
  } top_s;
  top_s s_r, s_nxt;

  logic [1:0] req;
  logic [3:0] cond0_r, cond1_r;

  function automatic logic is_even(input logic [1:0] d);
    is_even = (desig_e'(d) == DESIG_SECOND) ||
              (desig_e'(d) == DESIG_FOURTH);
  endfunction

  function automatic logic [31:0] ctrl_word(input logic [6:0] c);
    ctrl_word = {25'h0, c};
  endfunction

  // ---------------------------------------------------------------
  // per-port qualification
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_port
      logic [6:0] c;
      logic [3:0] cd;
      assign c = (g == 0) ? s_r.ctrl0 : s_r.ctrl1;
      assign cd = (g == 0) ? I_COND0 : I_COND1;
      serint_port u_port (
        .i_clk(I_CLK),
        .i_arst_n(I_ARST_N),
        .i_mreset(I_MASTER_RESET_IN),
        .i_enable(c[`CTRL_ENA_LSB +: `CTRL_ENA_W]),
        .i_gate(c[`CTRL_GATE_BIT]),
        .i_cond(cd),
        .o_req(req[g])
      );
    end
  endgenerate

  assign cond0_r = I_COND0;
  assign cond1_r = I_COND1;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic e0, e1, g0, g1;
    s_nxt = s_r;
    e0 = is_even(s_r.ctrl0[`CTRL_DESIG_LSB +: `CTRL_DESIG_W]);
    e1 = is_even(s_r.ctrl1[`CTRL_DESIG_LSB +: `CTRL_DESIG_W]);
    g0 = s_r.ctrl0[`CTRL_GATE_BIT];
    g1 = s_r.ctrl1[`CTRL_GATE_BIT];
    s_nxt.wait_n = 1'b0;
    unique case (s_r.bus)
      BUS_IDLE: begin
        if (I_WRITE) begin
          // write lands on the answer edge, when the master sees ready
          s_nxt.wait_n = 1'b1;
          s_nxt.bus = BUS_ANSWER;
        end else if (I_READ) begin
          unique case (I_ADDRESS)
            `OFS_CTRL0: s_nxt.rdata = ctrl_word(s_r.ctrl0);
            `OFS_CTRL1: s_nxt.rdata = ctrl_word(s_r.ctrl1);
            `OFS_STAT0: s_nxt.rdata = {26'h0, g0, req[0], cond0_r};
            `OFS_STAT1: s_nxt.rdata = {26'h0, g1, req[1], cond1_r};
            default: s_nxt.rdata = 32'h00000000;
          endcase
          s_nxt.wait_n = 1'b1;
          s_nxt.bus = BUS_ANSWER;
        end
      end
      BUS_ANSWER: begin
        if (I_WRITE) begin
          unique case (I_ADDRESS)
            `OFS_CTRL0: s_nxt.ctrl0 = I_WRITEDATA[6:0];
            `OFS_CTRL1: s_nxt.ctrl1 = I_WRITEDATA[6:0];
            default: ;
          endcase
        end
        s_nxt.bus = BUS_IDLE;
      end
    endcase
    // R01 even line routing
    // R06 gate clear releases pin
    s_nxt.even = (e0 && g0 && req[0]) || (e1 && g1 && req[1]);
    s_nxt.even_oe = (e0 && g0) || (e1 && g1);
    // R02 odd line routing
    s_nxt.odd = (!e0 && g0 && req[0]) || (!e1 && g1 && req[1]);
    s_nxt.odd_oe = (!e0 && g0) || (!e1 && g1);
    // R07 master reset defaults
    if (I_MASTER_RESET_IN) begin
      s_nxt.ctrl0 = `CTRL0_RST;
      s_nxt.ctrl1 = `CTRL1_RST;
      s_nxt.even = 1'b0;
      s_nxt.odd = 1'b0;
      s_nxt.even_oe = 1'b0;
      s_nxt.odd_oe = 1'b0;
    end
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      s_r <= '{ctrl0: `CTRL0_RST, ctrl1: `CTRL1_RST, bus: BUS_IDLE,
               rdata: 32'h00000000, wait_n: 1'b0, even: 1'b0,
               even_oe: 1'b0, odd: 1'b0, odd_oe: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign O_READDATA = s_r.rdata;
  assign O_WAITREQUEST = !s_r.wait_n;
  assign O_SERIAL_INT_OUT_EVEN_PORT = s_r.even;
  assign O_SERIAL_INT_OUT_EVEN_PORT_OE = s_r.even_oe;
  assign O_SERIAL_INT_OUT_ODD_PORT = s_r.odd;
  assign O_SERIAL_INT_OUT_ODD_PORT_OE = s_r.odd_oe;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_even_route: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (req[0] && s_r.ctrl0[4] && is_even(s_r.ctrl0[6:5])
     && !I_MASTER_RESET_IN) |=> O_SERIAL_INT_OUT_EVEN_PORT) // R01
    else $error("even line missed port 0 request");
  a_odd_route: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (req[1] && s_r.ctrl1[4] && !is_even(s_r.ctrl1[6:5])
     && !I_MASTER_RESET_IN) |=> O_SERIAL_INT_OUT_ODD_PORT) // R02
    else $error("odd line missed port 1 request");
  a_high_needs_oe: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    O_SERIAL_INT_OUT_EVEN_PORT |-> O_SERIAL_INT_OUT_EVEN_PORT_OE) // R03
    else $error("even line high while released");
  a_cond_raises: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (I_COND0[2] && s_r.ctrl0[2] && s_r.ctrl0[4] && !s_r.ctrl0[5]
     && !I_MASTER_RESET_IN)[*3] |-> O_SERIAL_INT_OUT_ODD_PORT) // R04
    else $error("enabled tx empty did not raise line");
  a_disable_drops: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (s_r.ctrl0 == 7'h10 && s_r.ctrl1 == 7'h30)[*3]
    |-> !O_SERIAL_INT_OUT_ODD_PORT && !O_SERIAL_INT_OUT_EVEN_PORT) // R05
    else $error("line high with all sources disabled");
  a_gate_float: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (!s_r.ctrl0[4] && !s_r.ctrl1[4]) |=>
    !O_SERIAL_INT_OUT_ODD_PORT_OE && !O_SERIAL_INT_OUT_EVEN_PORT_OE) // R06
    else $error("line driven with both gates clear");
  a_mreset_idle: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    I_MASTER_RESET_IN |=> s_r.ctrl0 == `CTRL0_RST &&
    !O_SERIAL_INT_OUT_ODD_PORT && !O_SERIAL_INT_OUT_EVEN_PORT) // R07
    else $error("master reset did not restore defaults");
  a_bus_answer: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    ((I_READ || I_WRITE) && s_r.bus == BUS_IDLE) |=> !O_WAITREQUEST
    ##1 O_WAITREQUEST)
    else $error("bus answer not one cycle after request");
  c_even_fire: cover property (@(posedge I_CLK) O_SERIAL_INT_OUT_EVEN_PORT);
  c_odd_fire: cover property (@(posedge I_CLK) O_SERIAL_INT_OUT_ODD_PORT);
  c_float: cover property (@(posedge I_CLK)
    $fell(O_SERIAL_INT_OUT_ODD_PORT_OE));
endmodule
`default_nettype wire

// ---- testbench/serint_host_pic.sv ----
// host interrupt controller input model for one interrupt line
`timescale 1ns/1ps
`default_nettype none
module serint_host_pic (
  // clock
  input wire logic i_clk,
  // line from the router
  input wire logic i_line,
  input wire logic i_oe,
  // level seen by the host
  output logic o_level
);
  logic last_r;
  int seen_r;
  // ---------------------------------------------------------------
  // line resolution
  // ---------------------------------------------------------------
  // a released line has no pull: show a toggling level, not a held one
  assign o_level = i_oe ? i_line : ~last_r;
  always_ff @(posedge i_clk) begin
    last_r <= o_level;
    if (i_oe && i_line && !last_r) begin
      seen_r <= seen_r + 1;
    end
  end
  initial begin
    last_r = 1'b0;
    seen_r = 0;
  end
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
// self-checking bench of the serial interrupt router
`include "serint_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import serint_pkg::*;
  logic clk, arst_n, mres, rd_en, wr_en, wreq, ev, ev_oe, od, od_oe;
  logic lv_e, lv_o;
  logic [3:0] k0, k1, addr;
  logic [31:0] wdata, rdata, rd;
  int fails, checked, seed, i;
  serint_router dut (.I_CLK(clk), .I_ARST_N(arst_n),
    .I_MASTER_RESET_IN(mres), .I_COND0(k0), .I_COND1(k1),
    .I_ADDRESS(addr), .I_READ(rd_en), .I_WRITE(wr_en),
    .I_WRITEDATA(wdata), .O_READDATA(rdata), .O_WAITREQUEST(wreq),
    .O_SERIAL_INT_OUT_EVEN_PORT(ev), .O_SERIAL_INT_OUT_EVEN_PORT_OE(ev_oe),
    .O_SERIAL_INT_OUT_ODD_PORT(od), .O_SERIAL_INT_OUT_ODD_PORT_OE(od_oe));
  serint_host_pic host_e (.i_clk(clk), .i_line(ev), .i_oe(ev_oe),
    .o_level(lv_e));
  serint_host_pic host_o (.i_clk(clk), .i_line(od), .i_oe(od_oe),
    .o_level(lv_o));
  // ---------------------------------------------------------------
  // expectations and checks
  // ---------------------------------------------------------------
  // result is {even oe, even line, odd oe, odd line}
  function automatic logic [3:0] exp_irq(logic [6:0] a, logic [6:0] b,
    logic [3:0] x, logic [3:0] y);
    logic ra, rb;
    ra = (|(a[3:0] & x)) & a[4];
    rb = (|(b[3:0] & y)) & b[4];
    return {(a[5] & a[4]) | (b[5] & b[4]), (a[5] & ra) | (b[5] & rb),
      (!a[5] & a[4]) | (!b[5] & b[4]), (!a[5] & ra) | (!b[5] & rb)};
  endfunction
  task automatic finish_test;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %0t reg %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_irq(input logic [3:0] exp);
    logic [3:0] got;
    got = {ev_oe, ev_oe & ev & lv_e, od_oe, od_oe & od & lv_o};
    checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %0t lines %b exp %b", $time, got, exp);
    end
  endtask
  // ---------------------------------------------------------------
  // bus cycle and scenario step
  // ---------------------------------------------------------------
  task automatic bus(input logic wr, input logic [3:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    addr <= a;
    wdata <= d;
    wr_en <= wr;
    rd_en <= !wr;
    @(posedge clk);
    while (wreq !== 1'b0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n >= 50) begin
      fails++;
    end
    rd = rdata;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    @(posedge clk);
  endtask
  task automatic setup(input logic [6:0] a, input logic [6:0] b,
    input logic [3:0] x, input logic [3:0] y);
    bus(1'b1, `OFS_CTRL0, {25'h0, a});
    bus(1'b1, `OFS_CTRL1, {25'h0, b});
    k0 <= x;
    k1 <= y;
    repeat (4) @(posedge clk);
    chk_irq(exp_irq(a, b, x, y));
  endtask
  // ---------------------------------------------------------------
  // clock, watchdog and main sequence
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    finish_test();
  end
  initial begin
    {arst_n, mres, rd_en, wr_en, addr, wdata, k0, k1} = '0;
    seed = 1722;
    fails = 0;
    checked = 0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    bus(1'b0, `OFS_CTRL0, 32'h0);
    chk_reg(rd, 32'h00000000);
    bus(1'b0, `OFS_CTRL1, 32'h0);
    chk_reg(rd, 32'h00000020);
    bus(1'b0, 4'h2, 32'h0);
    chk_reg(rd, 32'h00000000);
    // every designation against every single condition
    for (i = 0; i < 16; i++) begin
      setup({i[3:2], 5'h1F}, 7'h00, 4'h1 << i[1:0], 4'h0);
    end
    setup(7'h31, 7'h00, 4'h8, 4'h0);
    setup(7'h1F, 7'h2F, 4'hF, 4'hF);
    setup(7'h1F, 7'h3F, 4'hF, 4'hF);
    // host service clears the pending conditions
    setup(7'h1F, 7'h3F, 4'h0, 4'h0);
    setup(7'h10, 7'h30, 4'hF, 4'hF);
    for (i = 0; i < 200; i++) begin
      setup(7'($random(seed)), 7'($random(seed)), 4'($random(seed)),
        4'($random(seed)));
    end
    setup(7'h1F, 7'h3F, 4'hF, 4'hF);
    bus(1'b0, `OFS_STAT0, 32'h0);
    chk_reg(rd, 32'h0000003F);
    mres <= 1'b1;
    @(posedge clk);
    mres <= 1'b0;
    repeat (3) @(posedge clk);
    chk_irq(4'h0);
    bus(1'b0, `OFS_CTRL1, 32'h0);
    chk_reg(rd, 32'h00000020);
    finish_test();
  end
endmodule
`default_nettype wire
